// File: rtl/afe_pin_logic.sv
// Purpose: Pin-level digital logic of a single-channel delta-sigma front end
// Assumes: mclk is the master clock; pins are asynchronous to it
// Notes:   Serial clock is oversampled, so it must stay well below mclk/6
`timescale 1ns/100ps

module afe_pin_logic #(
  parameter int WORD_W = 24
) (
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  input  wire logic                                watchdog_reset,
  input  wire logic                                external_clock_select,
  input  wire logic                                external_reference_select,
  input  wire logic                                bitstream_output_enable,
  input  wire logic                                ready_pin_drive_select,
  input  wire logic [afe_pin_pkg::PRE_W-1:0]       prescale,
  input  wire logic [afe_pin_pkg::OSR_CODE_W-1:0]  osr_code,
  input  wire logic                                modulator_bit,
  input  wire logic [WORD_W-1:0]                   sample_data,
  input  wire logic                                sample_valid,
  output logic                                     sample_ready,
  input  wire logic                                reset_pin_n,
  input  wire logic                                crystal_out_mode_pin,
  input  wire logic                                crystal_in_clock_in,
  input  wire logic                                data_ready_n_in,
  input  wire logic                                cs_n,
  input  wire logic                                sck,
  input  wire logic                                sdi,
  output logic                                     bitstream_pin_out,
  output logic                                     bitstream_pin_oe,
  output logic                                     data_ready_n_out,
  output logic                                     data_ready_n_oe,
  output logic                                     sdo_out,
  output logic                                     sdo_oe,
  output logic                                     oscillator_enable,
  output logic                                     clock_from_pin,
  output logic                                     internal_ref_enable,
  output logic                                     ref_out_switch_on,
  output logic                                     two_wire_mode,
  output logic [afe_pin_pkg::GAIN_W-1:0]           gain_sel,
  output logic                                     boost_sel,
  output logic [afe_pin_pkg::OSR_SEL_W-1:0]        osr_sel,
  output logic                                     analog_clock_en,
  output logic                                     sample_clock_en,
  output logic                                     rate_clock_en
);

  localparam int CNT_W = $clog2(WORD_W) + 1;
  localparam logic [CNT_W-1:0] WORD_END = CNT_W'(WORD_W);
  localparam int PC = afe_pin_pkg::PIN_COUNT;

  // Reset release through two flops
  logic rst_meta_q, rst_int_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_int_n  <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_int_n  <= rst_meta_q;
    end
  end

  // Pin synchroniser: three stages, a change counts when stages 2 and 3 agree
  logic [PC-1:0] pins_raw, s1_q, s2_q, s3_q, filt_q, filt_d;
  assign pins_raw = {crystal_in_clock_in, data_ready_n_in,
                     crystal_out_mode_pin, reset_pin_n, sdi, cs_n, sck};
  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
  end
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s1_q   <= afe_pin_pkg::PIN_RESET_VAL;
      s2_q   <= afe_pin_pkg::PIN_RESET_VAL;
      s3_q   <= afe_pin_pkg::PIN_RESET_VAL;
      filt_q <= afe_pin_pkg::PIN_RESET_VAL;
    end else begin
      s1_q   <= pins_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_high;
  assign sck_rise = filt_d[afe_pin_pkg::PIN_SCK] & ~filt_q[afe_pin_pkg::PIN_SCK];
  assign sck_fall = ~filt_d[afe_pin_pkg::PIN_SCK] & filt_q[afe_pin_pkg::PIN_SCK];
  assign cs_fall  = ~filt_d[afe_pin_pkg::PIN_CS] & filt_q[afe_pin_pkg::PIN_CS];
  assign cs_high  = filt_d[afe_pin_pkg::PIN_CS];

  // Mode and 2-wire select latch
  logic [2:0] settle_q, settle_d;
  logic       two_wire_q, two_wire_d, boost_q, boost_d;
  logic [afe_pin_pkg::GAIN_W-1:0]    gain_q, gain_d;
  logic [afe_pin_pkg::OSR_SEL_W-1:0] osr_sel_q, osr_sel_d;
  logic mr_active, mr_release, latch_ev;

  // Reset pin only acts as master reset while in SPI mode
  assign mr_active  = (two_wire_q == afe_pin_pkg::MODE_SPI) &
                      ~filt_q[afe_pin_pkg::PIN_RST];
  assign mr_release = mr_active & filt_d[afe_pin_pkg::PIN_RST];
  assign latch_ev   = (settle_q == afe_pin_pkg::SETTLE_CYCLES) |
                      mr_release | watchdog_reset;

  always_comb begin
    settle_d  = (settle_q == afe_pin_pkg::SETTLE_DONE) ?
                settle_q : settle_q + 3'h1;
    two_wire_d = two_wire_q;
    gain_d     = gain_q;
    boost_d    = boost_q;
    osr_sel_d  = osr_sel_q;
    if (latch_ev) begin
      // With the crystal in use the mode pin is a crystal pin: SPI only
      two_wire_d = external_clock_select &
                   filt_d[afe_pin_pkg::PIN_MODE];
    end
    if (latch_ev && two_wire_d == afe_pin_pkg::MODE_TWO_WIRE) begin
      gain_d    = {filt_d[afe_pin_pkg::PIN_DR],
                   filt_d[afe_pin_pkg::PIN_OSC1]};
      boost_d   = filt_d[afe_pin_pkg::PIN_CS];
      osr_sel_d = {filt_d[afe_pin_pkg::PIN_SDI],
                   filt_d[afe_pin_pkg::PIN_RST]};
    end
  end
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      settle_q   <= 3'h0;
      two_wire_q <= afe_pin_pkg::MODE_SPI;
      gain_q     <= '0;
      boost_q    <= 1'b0;
      osr_sel_q  <= '0;
    end else begin
      settle_q   <= settle_d;
      two_wire_q <= two_wire_d;
      gain_q     <= gain_d;
      boost_q    <= boost_d;
      osr_sel_q  <= osr_sel_d;
    end
  end

  // Clock tree enables; the enables stop and the counters clear under master reset
  logic [afe_pin_pkg::PRE_CNT_W-1:0] pre_cnt_q, pre_cnt_d, pre_max;
  logic [1:0]                        dm_cnt_q, dm_cnt_d;
  logic [afe_pin_pkg::OSR_CNT_W-1:0] osr_cnt_q, osr_cnt_d, osr_max;
  logic [afe_pin_pkg::DR_CNT_W-1:0]  dr_cnt_q, dr_cnt_d;
  logic analog_master_clock_en, digital_sample_clock_en, output_rate_clock_en, bs_q, bs_d;

  assign pre_max  = afe_pin_pkg::PRE_CNT_W'((4'h1 << prescale) - 4'h1);
  assign osr_max  = afe_pin_pkg::OSR_CNT_W'(
                    (afe_pin_pkg::OSR_BASE << osr_code) - 13'h0001);
  assign analog_master_clock_en = ~mr_active & (pre_cnt_q == pre_max);
  assign digital_sample_clock_en = analog_master_clock_en & (dm_cnt_q == afe_pin_pkg::DIGITAL_SAMPLE_CLOCK_LAST);
  assign output_rate_clock_en = digital_sample_clock_en & (osr_cnt_q == osr_max);

  always_comb begin
    pre_cnt_d = pre_cnt_q;
    dm_cnt_d  = dm_cnt_q;
    osr_cnt_d = osr_cnt_q;
    dr_cnt_d  = dr_cnt_q;
    bs_d      = bs_q;
    if (mr_active) begin
      pre_cnt_d = '0;
      dm_cnt_d  = '0;
      osr_cnt_d = '0;
      dr_cnt_d  = '0;
    end else begin
      pre_cnt_d = analog_master_clock_en ? '0 : pre_cnt_q + 1'b1;
      if (analog_master_clock_en) begin
        dm_cnt_d = dm_cnt_q + 2'h1;
        bs_d     = modulator_bit;
      end
      if (digital_sample_clock_en) begin
        osr_cnt_d = output_rate_clock_en ? '0 : osr_cnt_q + 1'b1;
      end
      // Not tied to any read: the pulse simply times out
      if (output_rate_clock_en) begin
        dr_cnt_d = afe_pin_pkg::DR_CNT_W'(
                   afe_pin_pkg::DR_HALF_DM << prescale);
      end else if (dr_cnt_q != '0) begin
        dr_cnt_d = dr_cnt_q - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pre_cnt_q <= '0;
      dm_cnt_q  <= '0;
      osr_cnt_q <= '0;
      dr_cnt_q  <= '0;
      bs_q      <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_d;
      dm_cnt_q  <= dm_cnt_d;
      osr_cnt_q <= osr_cnt_d;
      dr_cnt_q  <= dr_cnt_d;
      bs_q      <= bs_d;
    end
  end

  // Two-entry sample buffer between the converter and the serial output
  logic [WORD_W-1:0] mem_q [2];
  logic [WORD_W-1:0] mem_d [2];
  logic       wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, push, pop, buf_valid;
  logic [1:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] head;

  assign sample_ready = (cnt_q != 2'h2) & ~mr_active;
  assign push         = sample_valid & sample_ready;
  assign buf_valid    = (cnt_q != 2'h0);
  assign head         = mem_q[rd_ptr_q];

  always_comb begin
    mem_d    = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d    = cnt_q;
    if (mr_active) begin
      wr_ptr_d = 1'b0;
      rd_ptr_d = 1'b0;
      cnt_d    = 2'h0;
    end else begin
      if (push) begin
        mem_d[wr_ptr_q] = sample_data;
        wr_ptr_d        = ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_d = ~rd_ptr_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q    <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  // Serial engine: SPI command/read and 2-wire frames
  afe_pin_pkg::serial_state_t state_q, state_d;
  logic [CNT_W-1:0]              bit_cnt_q, bit_cnt_d;
  logic [afe_pin_pkg::CMD_W-1:0] cmd_q, cmd_d;
  logic [WORD_W-1:0]             sh_q, sh_d;
  logic                          sdo_q, sdo_d;

  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    cmd_d     = cmd_q;
    sh_d      = sh_q;
    sdo_d     = sdo_q;
    pop       = 1'b0;
    case (state_q)
      afe_pin_pkg::S_IDLE: begin
        if (!two_wire_q && !mr_active && cs_fall) begin
          state_d   = afe_pin_pkg::S_CMD;
          bit_cnt_d = '0;
        end else if (two_wire_q && output_rate_clock_en && buf_valid) begin
          state_d   = afe_pin_pkg::S_FRAME;
          sh_d      = head;
          pop       = 1'b1;
          bit_cnt_d = '0;
        end
      end
      afe_pin_pkg::S_CMD: begin
        if (sck_rise) begin
          cmd_d     = {cmd_q[afe_pin_pkg::CMD_W-2:0],
                       filt_d[afe_pin_pkg::PIN_SDI]};
          bit_cnt_d = bit_cnt_q + 1'b1;
          if (bit_cnt_q == CNT_W'(afe_pin_pkg::CMD_LAST_BIT)) begin
            bit_cnt_d = WORD_END;
            state_d   = cmd_d[afe_pin_pkg::CMD_READ_BIT] ?
                        afe_pin_pkg::S_READ : afe_pin_pkg::S_WRITE;
          end
        end
      end
      afe_pin_pkg::S_WRITE: begin
        state_d = afe_pin_pkg::S_WRITE;
      end
      afe_pin_pkg::S_READ: begin
        if (sck_fall) begin
          // Continuous read: each word end fetches the next sample
          if (bit_cnt_q == WORD_END) begin
            sdo_d     = buf_valid & head[WORD_W-1];
            sh_d      = buf_valid ? {head[WORD_W-2:0], 1'b0} : '0;
            pop       = buf_valid;
            bit_cnt_d = CNT_W'(1);
          end else begin
            sdo_d     = sh_q[WORD_W-1];
            sh_d      = {sh_q[WORD_W-2:0], 1'b0};
            bit_cnt_d = bit_cnt_q + 1'b1;
          end
        end
      end
      afe_pin_pkg::S_FRAME: begin
        if (sck_fall) begin
          if (bit_cnt_q == WORD_END) begin
            state_d = afe_pin_pkg::S_IDLE;
          end else begin
            sdo_d     = sh_q[WORD_W-1];
            sh_d      = {sh_q[WORD_W-2:0], 1'b0};
            bit_cnt_d = bit_cnt_q + 1'b1;
          end
        end
      end
      default: begin
        state_d = afe_pin_pkg::S_IDLE;
      end
    endcase
    // Chip select high or reset pin low ends any SPI transaction
    if (!two_wire_q && (cs_high || mr_active)) begin
      state_d = afe_pin_pkg::S_IDLE;
    end
  end
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_q   <= afe_pin_pkg::S_IDLE;
      bit_cnt_q <= '0;
      cmd_q     <= '0;
      sh_q      <= '0;
      sdo_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      cmd_q     <= cmd_d;
      sh_q      <= sh_d;
      sdo_q     <= sdo_d;
    end
  end

  // Pin drivers
  logic spi_mode, dr_low;
  assign spi_mode          = (two_wire_q == afe_pin_pkg::MODE_SPI);
  assign dr_low            = (dr_cnt_q != '0);
  assign bitstream_pin_out = bs_q;
  assign bitstream_pin_oe  = bitstream_output_enable & spi_mode;
  assign data_ready_n_out  = ~dr_low;
  // The pin is a gain input in 2-wire mode, so never driven there
  assign data_ready_n_oe   = spi_mode & ~bitstream_output_enable &
                             (dr_low | ready_pin_drive_select);
  assign sdo_out           = sdo_q;
  assign sdo_oe            = (state_q == afe_pin_pkg::S_READ) |
                             (state_q == afe_pin_pkg::S_FRAME);
  assign oscillator_enable = ~external_clock_select;
  assign clock_from_pin    = external_clock_select;
  assign internal_ref_enable = ~external_reference_select;
  assign ref_out_switch_on   = ~external_reference_select;
  assign two_wire_mode     = two_wire_q;
  assign gain_sel          = gain_q;
  assign boost_sel         = boost_q;
  assign osr_sel           = osr_sel_q;
  assign analog_clock_en   = analog_master_clock_en;
  assign sample_clock_en   = digital_sample_clock_en;
  assign rate_clock_en     = output_rate_clock_en;

  a_bs_off_hiz: assert property (@(posedge mclk) disable iff (!rst_int_n)
    !bitstream_output_enable |-> !bitstream_pin_oe)
    else $error("bitstream pin driven while disabled");
  a_bs_follows_mod: assert property (@(posedge mclk) disable iff (!rst_int_n)
    analog_master_clock_en |=> bitstream_pin_out == $past(modulator_bit))
    else $error("bitstream not updated on analog clock");
  a_dr_off_bs: assert property (@(posedge mclk) disable iff (!rst_int_n)
    bitstream_pin_oe |-> !data_ready_n_oe)
    else $error("ready pin driven with bitstream enabled");
  a_bs_two_wire: assert property (@(posedge mclk) disable iff (!rst_int_n)
    two_wire_q |-> !bitstream_pin_oe && !data_ready_n_oe)
    else $error("pin driven in 2-wire mode");
  a_dr_idle_drive: assert property (@(posedge mclk) disable iff (!rst_int_n)
    spi_mode && !bitstream_output_enable && !dr_low
      |-> data_ready_n_oe == ready_pin_drive_select)
    else $error("ready pin idle drive wrong");
  a_dr_pulse_load: assert property (@(posedge mclk) disable iff (!rst_int_n)
    output_rate_clock_en && !mr_active |=> dr_cnt_q == 5'(5'h02 << $past(prescale)))
    else $error("ready pulse width wrong");
  a_dr_pulse_run: assert property (@(posedge mclk) disable iff (!rst_int_n)
    dr_low && !output_rate_clock_en && !mr_active |=> dr_cnt_q == $past(dr_cnt_q) - 5'h01)
    else $error("ready pulse not counting down");
  a_mode_hold: assert property (@(posedge mclk) disable iff (!rst_int_n)
    !latch_ev |=> $stable(two_wire_q))
    else $error("mode changed without latch event");
  a_sel_hold: assert property (@(posedge mclk) disable iff (!rst_int_n)
    !latch_ev |=> $stable(gain_q) && $stable(boost_q) && $stable(osr_sel_q))
    else $error("2-wire selects changed between latches");
  a_reset_blocks: assert property (@(posedge mclk) disable iff (!rst_int_n)
    mr_active |=> state_q == afe_pin_pkg::S_IDLE && !sdo_oe)
    else $error("serial activity during reset pin low");
  a_reset_clock_stop: assert property (@(posedge mclk) disable iff (!rst_int_n)
    mr_active |-> !analog_master_clock_en ##1 !dr_low)
    else $error("clocks running during reset pin low");
  a_sdo_cmd_hiz: assert property (@(posedge mclk) disable iff (!rst_int_n)
    state_q == afe_pin_pkg::S_CMD || state_q == afe_pin_pkg::S_WRITE
      |-> !sdo_oe)
    else $error("serial output driven outside a read");
  a_sample_div4: assert property (@(posedge mclk) disable iff (!rst_int_n)
    digital_sample_clock_en |-> dm_cnt_q == 2'h3 && analog_master_clock_en)
    else $error("sample clock not analog clock over four");

endmodule // afe_pin_logic

// File: rtl/afe_pin_pkg.sv
// Purpose: Shared constants for the front-end pin function logic
// Assumes: One master clock domain; serial pins arrive asynchronously
// Notes:   Pin vector indices describe the synchroniser input order
package afe_pin_pkg;

  // Synchronised pin vector layout
  localparam int PIN_COUNT = 7;
  localparam int PIN_SCK   = 0;
  localparam int PIN_CS    = 1;
  localparam int PIN_SDI   = 2;
  localparam int PIN_RST   = 3;
  localparam int PIN_MODE  = 4;
  localparam int PIN_DR    = 5;
  localparam int PIN_OSC1  = 6;
  // Chip select idles high, everything else low
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 7'h02;

  // Interface mode encoding
  localparam logic MODE_SPI      = 1'b0;
  localparam logic MODE_TWO_WIRE = 1'b1;

  // Cycles for the pin synchroniser to fill before the power-on latch
  localparam logic [2:0] SETTLE_CYCLES = 3'h3;
  localparam logic [2:0] SETTLE_DONE   = 3'h4;

  // Clock tree: prescale 1/2/4/8, then divide by four
  localparam int         PRE_W       = 2;
  localparam int         PRE_CNT_W   = 3;
  localparam logic [1:0] DIGITAL_SAMPLE_CLOCK_LAST  = 2'h3;
  // Oversampling ratio is 32 shifted left by a 3-bit code
  localparam int          OSR_CODE_W = 3;
  localparam int          OSR_CNT_W  = 12;
  localparam logic [12:0] OSR_BASE   = 13'h0020;
  // Ready pulse lasts half a sample period: two analog clock periods
  localparam int         DR_CNT_W    = 5;
  localparam logic [4:0] DR_HALF_DM  = 5'h02;

  // Serial command framing
  localparam int CMD_W        = 8;
  localparam int CMD_READ_BIT = 0;
  localparam logic [3:0] CMD_LAST_BIT = 4'h7;

  // 2-wire pin select widths
  localparam int GAIN_W    = 2;
  localparam int OSR_SEL_W = 2;

  typedef enum {
    S_IDLE,
    S_CMD,
    S_WRITE,
    S_READ,
    S_FRAME
  } serial_state_t;

endpackage : afe_pin_pkg

// File: verification/afe_digital_pin_function_logic_tb_top.sv
// Purpose: Self-checking bench for the front-end pin function logic
// Assumes: 100 MHz mclk; design inputs driven at falling edges
// Notes:   OSR code stays 0 so rate periods stay short
`timescale 1ns/100ps
module afe_digital_pin_function_logic_tb_top;
  typedef struct packed { logic [2:0] in; logic [4:0] exp; } row_t;
  logic        mclk = 1'b0, rst_n, watchdog_reset, external_clock_select;
  logic        external_reference_select, bitstream_output_enable;
  logic        ready_pin_drive_select, modulator_bit, sample_valid;
  logic        reset_pin_n, crystal_out_mode_pin, crystal_in_clock_in;
  logic        data_ready_n_in, cs_n, sck, sdi, sample_ready;
  logic        bitstream_pin_out, bitstream_pin_oe, data_ready_n_out;
  logic        data_ready_n_oe, sdo_out, sdo_oe, oscillator_enable;
  logic        clock_from_pin, internal_ref_enable, ref_out_switch_on;
  logic        two_wire_mode, boost_sel, analog_clock_en;
  logic        sample_clock_en, rate_clock_en;
  logic [1:0]  prescale, gain_sel, osr_sel;
  logic [2:0]  osr_code;
  logic [23:0] sample_data;
  int          miscompares, checks, n, w, p, i;
  row_t rows [4] = '{'{3'h0, 5'h16}, '{3'h3, 5'h11}, '{3'h5, 5'h0F},
                     '{3'h6, 5'h08}};
  always #5 mclk = ~mclk;
  afe_pin_logic afe_pin_logic_inst (.*);
  afe_host_model afe_host_model_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // A wait that runs out of its bound ends the run as a failure
  task automatic time_out();
    miscompares++;
    print_verdict();
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return analog_clock_en;
      1: return sample_clock_en;
      default: return rate_clock_en;
    endcase
  endfunction
  // Cycles from one enable pulse to the next; 3000 cycles without one ends the run
  task automatic gap(input int s, output int c);
    int k;
    c = 0;
    for (k = 0; k < 3000 && pick(s) !== 1'b1; k++) @(negedge mclk);
    do begin
      @(negedge mclk);
      c++;
    end while (pick(s) !== 1'b1 && c < 3000);
    if (k >= 3000 || c >= 3000) time_out();
  endtask
  task automatic push(input logic [23:0] d);
    int k;
    sample_valid = 1'b1;
    sample_data = d;
    for (k = 0; k < 50 && sample_ready !== 1'b1; k++) @(negedge mclk);
    if (k >= 50) time_out();
    @(negedge mclk);
    sample_valid = 1'b0;
    // Let an edge pass so a following push does not re-raise valid at once
    @(negedge mclk);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (12) @(negedge mclk);
  endtask
  initial begin
    miscompares = 0;
    checks = 0;
    {watchdog_reset, external_reference_select, bitstream_output_enable,
     ready_pin_drive_select, modulator_bit, sample_valid,
     crystal_out_mode_pin, crystal_in_clock_in, data_ready_n_in} = '0;
    {external_clock_select, reset_pin_n} = 2'h3;
    prescale = '0;
    osr_code = '0;
    sample_data = '0;
    do_reset();
    chk(two_wire_mode, 0, "mode");
    for (i = 0; i < 4; i++) begin
      {external_clock_select, external_reference_select,
       bitstream_output_enable} = rows[i].in;
      @(negedge mclk);
      chk({oscillator_enable, clock_from_pin, internal_ref_enable,
           ref_out_switch_on, bitstream_pin_oe}, rows[i].exp, "levels");
    end
    {external_clock_select, bitstream_output_enable} = 2'h3;
    ready_pin_drive_select = 1'b1;
    {w, n} = '0;
    for (i = 0; i < 300; i++) begin
      modulator_bit = i[3];
      @(negedge mclk);
      if (data_ready_n_oe !== 1'b0) w++;
      if (bitstream_pin_out !== i[3]) n++;
    end
    chk(w, 0, "ready oe with bitstream on");
    chk(n, 0, "bitstream follows modulator");
    bitstream_output_enable = 1'b0;
    for (p = 0; p < 4; p++) begin
      prescale = p[1:0];
      ready_pin_drive_select = p[0];
      gap(2, n);
      gap(0, n);
      chk(n, 1 << p, "analog period");
      gap(1, n);
      chk(n, 4 << p, "sample period");
      gap(2, n);
      gap(2, n);
      chk(n, 128 << p, "rate period");
      w = 0;
      @(negedge mclk);
      while (data_ready_n_out === 1'b0 && w < 100) begin
        w++;
        @(negedge mclk);
      end
      if (w >= 100) time_out();
      chk(w, 2 << p, "ready width");
      chk({data_ready_n_out, data_ready_n_oe}, {1'b1, p[0]}, "idle");
    end
    prescale = 2'h0;
    push(24'hA5C3F1);
    push(24'h3C96E7);
    chk(sample_ready, 0, "buffer full");
    afe_host_model_inst.xfer(8'h00, 32);
    chk(afe_host_model_inst.rx_n, 0, "write drive");
    for (i = 0; i < 2; i++) begin
      afe_host_model_inst.xfer(8'h01, 31);
      chk(afe_host_model_inst.rx_n, 24, "read bits");
      chk(afe_host_model_inst.rx_q, i ? 24'h3C96E7 : 24'hA5C3F1, "word");
    end
    @(negedge mclk);
    chk(sample_ready, 1, "buffer drained");
    reset_pin_n = 1'b0;
    repeat (10) @(negedge mclk);
    chk(sample_ready, 0, "held ready");
    w = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (rate_clock_en !== 1'b0) w++;
    end
    chk(w, 0, "held rate");
    afe_host_model_inst.xfer(8'h01, 31);
    chk(afe_host_model_inst.rx_n, 0, "held read");
    @(negedge mclk);
    crystal_out_mode_pin = 1'b1;
    data_ready_n_in = 1'b1;
    afe_host_model_inst.set_pins(1'b1, 1'b1);
    bitstream_output_enable = 1'b1;
    do_reset();
    chk({two_wire_mode, gain_sel, boost_sel, osr_sel}, 6'h36, "sel");
    chk(bitstream_pin_oe, 0, "bitstream in 2-wire");
    {data_ready_n_in, crystal_in_clock_in, reset_pin_n} = 3'h3;
    afe_host_model_inst.set_pins(1'b0, 1'b0);
    repeat (10) @(negedge mclk);
    chk({two_wire_mode, gain_sel, boost_sel, osr_sel}, 6'h36, "hold");
    watchdog_reset = 1'b1;
    @(negedge mclk);
    watchdog_reset = 1'b0;
    repeat (10) @(negedge mclk);
    chk({two_wire_mode, gain_sel, boost_sel, osr_sel}, 6'h29, "relatch");
    push(24'h5AF00F);
    afe_host_model_inst.rx_n = 0;
    afe_host_model_inst.free_run = 1'b1;
    for (i = 0; i < 3000 && afe_host_model_inst.rx_n < 24; i++)
      @(negedge mclk);
    if (i >= 3000) time_out();
    repeat (300) @(negedge mclk);
    afe_host_model_inst.free_run = 1'b0;
    chk(afe_host_model_inst.rx_n, 24, "frame bits");
    chk(afe_host_model_inst.rx_q, 24'h5AF00F, "frame word");
    print_verdict();
  end
endmodule // afe_digital_pin_function_logic_tb_top

// File: verification/afe_host_model.sv
// Purpose: Host controller model on the serial pins
// Assumes: Mode 0,0 host; sck half period 100 ns, far below mclk rate
// Notes:   sck stands still outside frames unless free running is asked
`timescale 1ns/100ps
module afe_host_model (
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  logic [23:0] rx_q;
  int          rx_n;
  bit          free_run;
  bit          busy;
  initial begin
    busy = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rx_q = '0;
    rx_n = 0;
    free_run = 1'b0;
  end
  // Continuous clock for 2-wire; comes to rest low, never cuts a transfer
  always begin
    #100;
    if (free_run || (sck && !busy)) sck = ~sck;
  end
  // Falls land just before an mclk fall, so the device acts on one 25 to
  // 35 ns later: enable there says the fall was counted, enable before
  // sampling says it was not the fall that closed the frame
  always @(negedge sck) begin
    #30;
    if (sdo_oe === 1'b1) begin
      #50;
      if (sdo_oe === 1'b1) begin
        rx_q = {rx_q[22:0], sdo_out};
        rx_n = rx_n + 1;
      end
    end
  end
  task automatic set_pins(input logic cs, input logic di);
    cs_n = cs;
    sdi = di;
  endtask
  task automatic xfer(input logic [7:0] cmd, input int n);
    int i;
    rx_n = 0;
    busy = 1'b1;
    cs_n = 1'b0;
    #100;
    for (i = 0; i < n; i++) begin
      sdi = (i < 8) ? cmd[7-i] : 1'b0;
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    sdi = ~sdi;
    #400;
    busy = 1'b0;
  endtask
endmodule // afe_host_model
